/* hw/blit_pkg.sv */
// Constants, field layout and carrier types of the operand address generator
package blit_pkg;
    localparam int AW = 22;
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_DEPTH  = 8'h04;
    localparam logic [7:0] OFF_FG     = 8'h08;
    localparam logic [7:0] OFF_BG     = 8'h0C;
    localparam logic [7:0] OFF_TRANS  = 8'h10;
    localparam logic [7:0] OFF_SBASE  = 8'h14;
    localparam logic [7:0] OFF_PBASE  = 8'h18;
    localparam logic [7:0] OFF_DBASE  = 8'h1C;
    localparam logic [7:0] OFF_PITCH  = 8'h20;
    localparam logic [7:0] OFF_SXY    = 8'h24;
    localparam logic [7:0] OFF_PXY    = 8'h28;
    localparam logic [7:0] OFF_DXY    = 8'h2C;
    localparam logic [7:0] OFF_HSRC   = 8'h30;
    localparam logic [7:0] OFF_GO     = 8'h34;
    localparam logic [7:0] OFF_APER   = 8'h38;
    localparam int CTRL_SEL   = 8;
    localparam int CTRL_DSTEN = 10;
    localparam int CTRL_PATEN = 11;
    localparam int CTRL_EXPND = 12;
    localparam int CTRL_TMODE = 13;
    localparam int CTRL_TINV  = 16;
    localparam int DEPTH_XDIR = 2;
    localparam int XY_Y       = 16;
    localparam int FB_ONSCR   = 23;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [1:0] SRC_SELECT_A = 2'h0;
    localparam logic [1:0] SRC_SCREEN   = 2'h1;
    localparam logic [1:0] SRC_HOST     = 2'h2;
    localparam logic [2:0] TM_NONE    = 3'h0;
    localparam logic [2:0] TM_BITMAP  = 3'h1;
    localparam logic [2:0] TM_PATTERN = 3'h2;
    localparam logic [2:0] TM_SOURCE  = 3'h3;
    localparam logic [2:0] TM_DEST    = 3'h4;
    typedef enum logic [2:0] {
        ST_IDLE, ST_SRC, ST_PAT, ST_DST, ST_CALC, ST_WR
    } eng_state_t;
    typedef struct packed {
        logic          we;
        logic [AW-1:0] addr;
        logic [3:0]    be;
        logic [31:0]   data;
    } mem_req_t;
endpackage

/* hw/blit_operand_address_generator.sv */
// Operand fetch, raster operation and X-Y address generation engine
//
// The register offsets and register access over APB were decided locally.
`timescale 1ns/1ps
module blit_operand_address_generator
    import blit_pkg::*;
(
    input  wire logic          i_clock,      // Core clock
    input  wire logic          i_reset,      // Sync reset, high
    input  wire logic          i_psel,       // APB select
    input  wire logic          i_penable,    // APB enable
    input  wire logic          i_pwrite,     // APB write
    input  wire logic [7:0]    i_paddr,      // APB byte address
    input  wire logic [31:0]   i_pwdata,     // APB write data
    output logic      [31:0]   o_prdata,     // APB read data
    output logic               o_pready,     // APB ready
    output logic               o_pslverr,    // APB error
    input  wire logic          i_fb_req,     // Host buffer request
    input  wire logic          i_fb_we,      // Host write
    input  wire logic          i_fb_legacy,  // Aperture access
    input  wire logic [23:0]   i_fb_addr,    // Host address
    input  wire logic [3:0]    i_fb_be,      // Host byte enables
    input  wire logic [31:0]   i_fb_wdata,   // Host write data
    output logic               o_fb_ack,     // Host done pulse
    output logic      [31:0]   o_fb_rdata,   // Host read data
    output logic               o_mem_req,    // DRAM request
    output mem_req_t           o_mem,        // DRAM command
    output logic               o_mem_onscr,  // Access on-screen
    input  wire logic          i_mem_ack,    // DRAM done
    input  wire logic [31:0]   i_mem_rdata   // DRAM read data
);
    logic [31:0]   ctrl_reg, depth_reg, fg_reg, bg_reg, trans_reg;
    logic [31:0]   sbase_reg, pbase_reg, dbase_reg, pitch_reg;
    logic [31:0]   sxy_reg, pxy_reg, dxy_reg, hsrc_reg;
    logic [7:0]    aper_reg;
    eng_state_t    state_reg;
    logic          own_host_reg;
    logic [31:0]   src_reg, pat_reg, dst_reg, res_reg;
    logic [3:0]    wmask_reg;
    logic          bit_reg;
    logic          apb_do, apb_wr, go;
    logic [31:0]   rd_next;
    logic          err_next;
    logic [1:0]    csel;
    logic [2:0]    tmode;
    logic          dst_en, pat_en, expand, busy;
    logic [1:0]    bpp_m1;
    logic [3:0]    pmask;
    logic [31:0]   bmask;
    logic [AW-1:0] op_addr;
    logic [AW-1:0] s_lin, p_lin, d_lin;
    logic [1:0]    s_lane, p_lane, d_lane;
    logic [31:0]   s_pix, r_pix;
    logic          t_skip;
    logic [3:0]    t_mask;
    logic          host_pend, eng_want, eng_ack;
    mem_req_t      eng_cmd, host_cmd;
    logic [23:0]   host_full;

    assign csel   = ctrl_reg[CTRL_SEL +: 2];
    assign tmode  = ctrl_reg[CTRL_TMODE +: 3];
    assign dst_en = ctrl_reg[CTRL_DSTEN];
    assign pat_en = ctrl_reg[CTRL_PATEN];
    assign expand = ctrl_reg[CTRL_EXPND];
    assign bpp_m1 = depth_reg[1:0];
    assign busy   = (state_reg != ST_IDLE);

    // Y times pitch by shifted adds; an invalid fourth code adds nothing
    function automatic logic [AW-1:0] y_pitch(input logic [11:0] y,
                                              input logic [11:0] pc);
        logic [AW-1:0] yw;
        logic [AW-1:0] s;
        yw = AW'(y);
        s  = '0;
        case (pc[2:0])
            3'h3: s = s + (yw << 7);
            3'h4: s = s + (yw << 8);
            3'h5: s = s + (yw << 9);
            3'h6: s = s + (yw << 10);
            3'h7: s = s + (yw << 11);
            default: s = s;
        endcase
        case (pc[5:3])
            3'h2: s = s + (yw << 6);
            3'h3: s = s + (yw << 7);
            3'h4: s = s + (yw << 8);
            3'h5: s = s + (yw << 9);
            3'h6: s = s + (yw << 10);
            default: s = s;
        endcase
        case (pc[8:6])
            3'h1: s = s + (yw << 5);
            3'h2: s = s + (yw << 6);
            3'h3: s = s + (yw << 7);
            3'h4: s = s + (yw << 8);
            3'h5: s = s + (yw << 9);
            default: s = s;
        endcase
        case (pc[11:9])
            3'h1: s = s + (yw << 10);
            3'h2: s = s + (yw << 11);
            3'h3: s = s + (yw << 12);
            default: s = s;
        endcase
        return s;
    endfunction

    // Byte address of the pixel's low byte; bases start at DRAM zero
    function automatic logic [AW-1:0] lin(input logic [31:0] base,
                                          input logic [31:0] xy,
                                          input logic        bitx,
                                          input logic        xneg,
                                          input logic [1:0]  bm1,
                                          input logic [11:0] pc);
        logic [AW-1:0] xb;
        xb = bitx ? AW'(xy[15:3]) : AW'(xy[15:0]);
        if (xneg && !bitx) begin
            xb = xb - AW'(bm1);
        end
        return base[AW-1:0] + y_pitch(xy[XY_Y +: 12], pc) + xb;
    endfunction

    assign pmask = 4'((5'h1 << (5'(bpp_m1) + 5'h1)) - 5'h1);
    assign bmask = {{8{pmask[3]}}, {8{pmask[2]}},
                    {8{pmask[1]}}, {8{pmask[0]}}};
    assign s_lin  = lin(sbase_reg, sxy_reg, expand, depth_reg[DEPTH_XDIR],
                        bpp_m1, pitch_reg[11:0]);
    assign p_lin  = lin(pbase_reg, pxy_reg, 1'b0, depth_reg[DEPTH_XDIR],
                        bpp_m1, pitch_reg[11:0]);
    assign d_lin  = lin(dbase_reg, dxy_reg, 1'b0, depth_reg[DEPTH_XDIR],
                        bpp_m1, pitch_reg[11:0]);
    assign s_lane = s_lin[1:0];
    assign p_lane = p_lin[1:0];
    assign d_lane = d_lin[1:0];

    always_comb begin
        case (state_reg)
            ST_SRC:  op_addr = s_lin;
            ST_PAT:  op_addr = p_lin;
            default: op_addr = d_lin;
        endcase
    end

    // Source operand: colors, host word or fetched screen data
    always_comb begin
        case (csel)
            SRC_SCREEN: s_pix = src_reg;
            SRC_HOST:   s_pix = hsrc_reg;
            default:    s_pix = fg_reg;
        endcase
        if (expand) begin
            s_pix = bit_reg ? fg_reg : bg_reg;
        end
    end

    always_comb begin
        for (int i = 0; i < 32; i++) begin
            r_pix[i] = ctrl_reg[{pat_reg[i], s_pix[i], dst_reg[i]}];
        end
    end

    // Transparency decisions folded into one byte mask
    always_comb begin
        t_skip = 1'b0;
        t_mask = pmask;
        case (tmode)
            TM_BITMAP:  t_skip = expand && !bit_reg;
            TM_SOURCE:  t_skip = (((s_pix ^ trans_reg) & bmask) == '0)
                                 ^ ctrl_reg[CTRL_TINV];
            TM_DEST:    t_skip = (((dst_reg ^ trans_reg) & bmask) == '0)
                                 ^ ctrl_reg[CTRL_TINV];
            TM_PATTERN: begin
                for (int b = 0; b < 4; b++) begin
                    if (pat_reg[b*8 +: 8] == 8'h00) begin
                        t_mask[b] = 1'b0;
                    end
                end
            end
            default: t_skip = 1'b0;
        endcase
        if (t_skip) begin
            t_mask = 4'h0;
        end
    end

    // APB slave: ready follows one cycle into the access phase
    assign apb_do = i_psel && i_penable && !o_pready;
    assign apb_wr = i_psel && i_penable && o_pready && i_pwrite;
    assign go     = apb_wr && (i_paddr == OFF_GO) && i_pwdata[0] && !busy;

    always_comb begin
        err_next = 1'b0;
        case (i_paddr)
            OFF_CTRL:  rd_next = ctrl_reg;
            OFF_DEPTH: rd_next = depth_reg;
            OFF_FG:    rd_next = fg_reg;
            OFF_BG:    rd_next = bg_reg;
            OFF_TRANS: rd_next = trans_reg;
            OFF_SBASE: rd_next = sbase_reg;
            OFF_PBASE: rd_next = pbase_reg;
            OFF_DBASE: rd_next = dbase_reg;
            OFF_PITCH: rd_next = pitch_reg;
            OFF_SXY:   rd_next = sxy_reg;
            OFF_PXY:   rd_next = pxy_reg;
            OFF_DXY:   rd_next = dxy_reg;
            OFF_HSRC:  rd_next = hsrc_reg;
            OFF_GO:    rd_next = {31'h0000_0000, busy};
            OFF_APER:  rd_next = {24'h00_0000, aper_reg};
            default: begin
                rd_next  = RST_WORD;
                err_next = 1'b1;
            end
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_pready  <= 1'b0;
            o_prdata  <= RST_WORD;
            o_pslverr <= 1'b0;
        end else begin
            o_pready  <= apb_do;
            o_pslverr <= apb_do && err_next;
            o_prdata  <= (apb_do && !i_pwrite) ? rd_next : RST_WORD;
        end
    end

    // Whole-word writes only; the bus carries no byte strobes
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            ctrl_reg  <= RST_WORD;
            depth_reg <= RST_WORD;
            fg_reg    <= RST_WORD;
            bg_reg    <= RST_WORD;
            trans_reg <= RST_WORD;
            sbase_reg <= RST_WORD;
            pbase_reg <= RST_WORD;
            dbase_reg <= RST_WORD;
            pitch_reg <= RST_WORD;
            sxy_reg   <= RST_WORD;
            pxy_reg   <= RST_WORD;
            dxy_reg   <= RST_WORD;
            hsrc_reg  <= RST_WORD;
            aper_reg  <= 8'h00;
        end else if (apb_wr) begin
            case (i_paddr)
                OFF_CTRL:  ctrl_reg  <= i_pwdata;
                OFF_DEPTH: depth_reg <= i_pwdata;
                OFF_FG:    fg_reg    <= i_pwdata;
                OFF_BG:    bg_reg    <= i_pwdata;
                OFF_TRANS: trans_reg <= i_pwdata;
                OFF_SBASE: sbase_reg <= i_pwdata;
                OFF_PBASE: pbase_reg <= i_pwdata;
                OFF_DBASE: dbase_reg <= i_pwdata;
                OFF_PITCH: pitch_reg <= i_pwdata;
                OFF_SXY:   sxy_reg   <= i_pwdata;
                OFF_PXY:   pxy_reg   <= i_pwdata;
                OFF_DXY:   dxy_reg   <= i_pwdata;
                OFF_HSRC:  hsrc_reg  <= i_pwdata;
                OFF_APER:  aper_reg  <= i_pwdata[7:0];
                default:   aper_reg  <= aper_reg;
            endcase
        end
    end

    // Host path: aperture picks a 64K page, bit 23 marks on-screen
    assign host_full = i_fb_legacy ? {aper_reg, i_fb_addr[15:0]}
                                   : i_fb_addr;
    assign host_cmd  = '{we: i_fb_we, addr: host_full[AW-1:0],
                         be: i_fb_be, data: i_fb_wdata};
    assign host_pend = i_fb_req && !o_fb_ack;
    assign eng_want  = (state_reg == ST_SRC) || (state_reg == ST_PAT) ||
                       (state_reg == ST_DST) || (state_reg == ST_WR);
    assign eng_ack   = o_mem_req && i_mem_ack && !own_host_reg;
    assign eng_cmd   = '{we: (state_reg == ST_WR),
                         addr: {op_addr[AW-1:2], 2'b00},
                         be: (state_reg == ST_WR) ?
                             4'(wmask_reg << d_lane) : 4'hF,
                         data: 32'(res_reg << {d_lane, 3'b000})};

    // Host wins an idle port so plain accesses proceed while busy
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_mem_req    <= 1'b0;
            own_host_reg <= 1'b0;
            o_mem        <= '0;
            o_mem_onscr  <= 1'b0;
        end else if (o_mem_req) begin
            if (i_mem_ack) begin
                o_mem_req <= 1'b0;
            end
        end else if (host_pend) begin
            o_mem_req    <= 1'b1;
            own_host_reg <= 1'b1;
            o_mem        <= host_cmd;
            o_mem_onscr  <= host_full[FB_ONSCR];
        end else if (eng_want) begin
            o_mem_req    <= 1'b1;
            own_host_reg <= 1'b0;
            o_mem        <= eng_cmd;
            o_mem_onscr  <= 1'b0;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_fb_ack   <= 1'b0;
            o_fb_rdata <= RST_WORD;
        end else begin
            o_fb_ack <= o_mem_req && i_mem_ack && own_host_reg;
            if (o_mem_req && i_mem_ack && own_host_reg) begin
                o_fb_rdata <= i_mem_rdata;
            end
        end
    end

    // Engine sequence: fetch what is enabled, compute, write
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            state_reg <= ST_IDLE;
            src_reg   <= RST_WORD;
            pat_reg   <= RST_WORD;
            dst_reg   <= RST_WORD;
            res_reg   <= RST_WORD;
            wmask_reg <= 4'h0;
            bit_reg   <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (go) begin
                        src_reg <= RST_WORD;
                        pat_reg <= RST_WORD;
                        dst_reg <= RST_WORD;
                        bit_reg <= hsrc_reg[sxy_reg[4:0]];
                        if (csel == SRC_SCREEN) begin
                            state_reg <= ST_SRC;
                        end else if (pat_en) begin
                            state_reg <= ST_PAT;
                        end else if (dst_en) begin
                            state_reg <= ST_DST;
                        end else begin
                            state_reg <= ST_CALC;
                        end
                    end
                end
                ST_SRC: begin
                    if (eng_ack) begin
                        src_reg <= (i_mem_rdata >> {s_lane, 3'b000})
                                   & bmask;
                        bit_reg <= i_mem_rdata[{s_lane, sxy_reg[2:0]}];
                        if (pat_en) begin
                            state_reg <= ST_PAT;
                        end else if (dst_en) begin
                            state_reg <= ST_DST;
                        end else begin
                            state_reg <= ST_CALC;
                        end
                    end
                end
                ST_PAT: begin
                    if (eng_ack) begin
                        pat_reg <= (i_mem_rdata >> {p_lane, 3'b000})
                                   & bmask;
                        state_reg <= dst_en ? ST_DST : ST_CALC;
                    end
                end
                ST_DST: begin
                    if (eng_ack) begin
                        dst_reg <= (i_mem_rdata >> {d_lane, 3'b000})
                                   & bmask;
                        state_reg <= ST_CALC;
                    end
                end
                ST_CALC: begin
                    res_reg   <= r_pix & bmask;
                    wmask_reg <= t_mask;
                    state_reg <= (t_mask == 4'h0) ? ST_IDLE : ST_WR;
                end
                ST_WR: begin
                    if (eng_ack) begin
                        state_reg <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_reset);

    AST_NO_SRC_FETCH: assert property (
        (state_reg == ST_SRC) |-> (csel == SRC_SCREEN))
        else $error("source fetched without screen source");
    AST_DST_GATED: assert property (
        (o_mem_req && !own_host_reg && !o_mem.we
         && state_reg == ST_DST) |-> dst_en)
        else $error("destination read while disabled");
    AST_PAT_GATED: assert property (
        $rose(state_reg == ST_PAT) |-> pat_en)
        else $error("pattern fetched while disabled");
    AST_WORD_ALIGNED: assert property (
        o_mem_req |-> (o_mem.addr[1:0] == 2'b00 || own_host_reg))
        else $error("engine address not word aligned");
    AST_HOLD_REQ: assert property (
        (o_mem_req && !i_mem_ack) |=> (o_mem_req && $stable(o_mem)))
        else $error("memory request dropped before ack");
    AST_HOST_ACK: assert property (
        (o_mem_req && own_host_reg && i_mem_ack) |=> o_fb_ack ##1 !o_fb_ack)
        else $error("host access not acknowledged");
    AST_WR_MASK: assert property (
        (o_mem_req && !own_host_reg && o_mem.we) |-> (o_mem.be != 4'h0))
        else $error("engine write with empty byte mask");
    AST_SKIP_NO_WR: assert property (
        (state_reg == ST_CALC && t_skip) |=> (state_reg == ST_IDLE))
        else $error("transparent pixel was written");
    AST_APB_READY: assert property (
        (i_psel && i_penable && !o_pready) |=> o_pready ##1 !o_pready)
        else $error("APB ready not a single pulse");

    COV_HOST: cover property (o_fb_ack);
    COV_ENG_WR: cover property (eng_ack && state_reg == ST_WR);
    COV_SKIP: cover property (state_reg == ST_CALC && t_mask == 4'h0);
    COV_BUSY_HOST: cover property (busy && o_fb_ack);
endmodule

/* verification/fb_dram_model.sv */
// Behavioural frame buffer DRAM answering host and engine requests
`timescale 1ns/1ps
module fb_dram_model
    import blit_pkg::*;
(
    input  wire logic        i_clock,    // Core clock
    input  wire logic        i_reset,    // Sync reset, high
    input  wire logic        i_mem_req,  // Request level
    input  wire mem_req_t    i_mem,      // Command
    input  wire logic [3:0]  i_delay,    // Wait cycles before ack
    output logic             o_mem_ack,  // One-cycle done
    output logic      [31:0] o_mem_rdata // Read data with ack
);
    logic [31:0] mem [0:1023];
    logic [3:0]  wait_cnt;
    int          reads;
    initial begin
        for (int i = 0; i < 1024; i++) mem[i] = 32'h0000_0000;
        reads = 0;
        o_mem_ack = 1'b0;
        o_mem_rdata = 32'h0000_0000;
    end
    // Linear addresses start at zero; small array keeps the run light
    always @(posedge i_clock) begin
        o_mem_ack <= 1'b0;
        // Data flips outside the ack cycle so stale reads show up
        o_mem_rdata <= ~o_mem_rdata;
        if (i_reset) wait_cnt <= 4'h0;
        else if (i_mem_req && !o_mem_ack) begin
            if (wait_cnt != i_delay) wait_cnt <= wait_cnt + 4'h1;
            else begin
                wait_cnt <= 4'h0;
                o_mem_ack <= 1'b1;
                o_mem_rdata <= mem[i_mem.addr[11:2]];
                if (!i_mem.we) reads <= reads + 1;
                for (int b = 0; b < 4; b++)
                    if (i_mem.we && i_mem.be[b])
                        mem[i_mem.addr[11:2]][8*b +: 8] <= i_mem.data[8*b +: 8];
            end
        end
    end
endmodule

/* verification/blit_operand_address_generator_tb.sv */
// Self-checking bench for the operand address generator
`timescale 1ns/1ps
module blit_operand_address_generator_tb;
    import blit_pkg::*;
    logic        i_clock, i_reset, i_psel, i_penable, i_pwrite, o_pready;
    logic        o_pslverr, i_fb_req, i_fb_we, i_fb_legacy, o_fb_ack;
    logic        o_mem_req, o_mem_onscr, i_mem_ack, er, on;
    logic [7:0]  i_paddr;
    logic [31:0] i_pwdata, o_prdata, i_fb_wdata, o_fb_rdata, i_mem_rdata, rd;
    logic [23:0] i_fb_addr;
    logic [3:0]  i_fb_be, mem_delay;
    mem_req_t    o_mem;
    int          bad_count, samples_checked, n0;
    blit_operand_address_generator dut_u (.i_clock, .i_reset, .i_psel,
        .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready,
        .o_pslverr, .i_fb_req, .i_fb_we, .i_fb_legacy, .i_fb_addr, .i_fb_be,
        .i_fb_wdata, .o_fb_ack, .o_fb_rdata, .o_mem_req, .o_mem,
        .o_mem_onscr, .i_mem_ack, .i_mem_rdata);
    fb_dram_model mem_u (.i_clock, .i_reset, .i_mem_req(o_mem_req),
        .i_mem(o_mem), .i_delay(mem_delay), .o_mem_ack(i_mem_ack),
        .o_mem_rdata(i_mem_rdata));
    task automatic check(input string what, input logic [31:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic close_out();
        $display("Mismatches %0d, checks %0d", bad_count, samples_checked);
        if (bad_count == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic give_up(input string what);
        bad_count++;
        $display("[FAIL] %s expected answer seen none", what);
        close_out();
    endtask
    task automatic apb(input logic we, input logic [7:0] a,
                       input logic [31:0] d);
        int n = 0;
        i_psel <= 1'b1;
        i_pwrite <= we;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clock);
        i_penable <= 1'b1;
        do begin
            @(posedge i_clock);
            n++;
        end while (o_pready !== 1'b1 && n < 20);
        if (o_pready !== 1'b1) give_up("apb ready");
        rd = o_prdata;
        er = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        @(posedge i_clock);
    endtask
    task automatic fb(input logic we, leg, input logic [23:0] a,
                      input logic [31:0] d, input logic [3:0] be);
        int n = 0;
        on = 1'bx;
        i_fb_req <= 1'b1;
        i_fb_we <= we;
        i_fb_legacy <= leg;
        i_fb_addr <= a;
        i_fb_wdata <= d;
        i_fb_be <= be;
        do begin
            @(posedge i_clock);
            if (o_mem_req === 1'b1) on = o_mem_onscr;
            n++;
        end while (o_fb_ack !== 1'b1 && n < 30);
        if (o_fb_ack !== 1'b1) give_up("host ack");
        rd = o_fb_rdata;
        i_fb_req <= 1'b0;
        @(posedge i_clock);
    endtask
    task automatic wait_idle();
        int n = 0;
        do begin
            apb(1'b0, OFF_GO, 32'h0000_0000);
            n++;
        end while (rd[0] !== 1'b0 && n < 40);
        if (rd[0] !== 1'b0) give_up("engine idle");
    endtask
    task automatic regs_scn();
        apb(1'b0, OFF_CTRL, 32'h0000_0000);
        check("ctrl reset", rd, RST_WORD);
        apb(1'b1, OFF_FG, 32'h0000_005A);
        apb(1'b0, OFF_FG, 32'h0000_0000);
        check("fg readback", rd, 32'h0000_005A);
        apb(1'b1, 8'h3C, 32'hFFFF_FFFF);
        check("unmapped error", {31'h0, er}, 32'h0000_0001);
    endtask
    task automatic host_scn();
        mem_delay <= 4'h3;
        fb(1'b1, 1'b0, 24'h80_0224, 32'h1122_3344, 4'hF);
        check("onscreen flag", {31'h0, on}, 32'h0000_0001);
        fb(1'b1, 1'b0, 24'h00_0020, 32'h00AB_0000, 4'h4);
        check("offscreen flag", {31'h0, on}, 32'h0000_0000);
        fb(1'b1, 1'b1, 24'h00_0230, 32'hCAFE_F00D, 4'hF);
        fb(1'b0, 1'b0, 24'h00_0230, 32'h0000_0000, 4'hF);
        check("aperture write", rd, 32'hCAFE_F00D);
        mem_delay <= 4'h0;
    endtask
    task automatic copy_scn();
        apb(1'b1, OFF_PITCH, 32'h0000_0050); // 64 + 32 bytes
        apb(1'b1, OFF_SBASE, 32'h0000_0020);
        apb(1'b1, OFF_SXY, 32'h0000_0002);
        apb(1'b1, OFF_DBASE, 32'h0000_0100);
        apb(1'b1, OFF_DXY, 32'h0003_0005);
        apb(1'b1, OFF_CTRL, 32'h0000_01CC);
        apb(1'b1, OFF_GO, 32'h0000_0001);
        fb(1'b0, 1'b0, 24'h00_0230, 32'h0000_0000, 4'hF);
        check("host read while busy", rd, 32'hCAFE_F00D);
        wait_idle();
        fb(1'b0, 1'b0, 24'h00_0224, 32'h0000_0000, 4'hF);
        check("copied pixel", rd, 32'h1122_AB44);
    endtask
    task automatic fill_scn();
        fb(1'b1, 1'b0, 24'h00_0580, 32'hFFFF_FFFF, 4'hF);
        apb(1'b1, OFF_PITCH, 32'h0000_0203); // 128 + 1024 bytes
        apb(1'b1, OFF_DXY, 32'h0001_0000);
        apb(1'b1, OFF_CTRL, 32'h0000_00CC);
        n0 = mem_u.reads;
        apb(1'b1, OFF_GO, 32'h0000_0001);
        wait_idle();
        check("reads skipped", 32'(mem_u.reads), 32'(n0));
        fb(1'b0, 1'b0, 24'h00_0580, 32'h0000_0000, 4'hF);
        check("fill pixel", rd, 32'hFFFF_FF5A);
    endtask
    task automatic rev_scn();
        apb(1'b1, OFF_DEPTH, 32'h0000_0005);
        apb(1'b1, OFF_SBASE, 32'h0000_0220);
        apb(1'b1, OFF_SXY, 32'h0000_0013);
        apb(1'b1, OFF_PBASE, 32'h0000_0020);
        apb(1'b1, OFF_PXY, 32'h0000_0003);
        apb(1'b1, OFF_DXY, 32'h0001_0003);
        apb(1'b1, OFF_CTRL, 32'h0000_49CC);
        n0 = mem_u.reads;
        apb(1'b1, OFF_GO, 32'h0000_0001);
        wait_idle();
        check("fetch count", 32'(mem_u.reads), 32'(n0 + 2));
        fb(1'b0, 1'b0, 24'h00_0580, 32'h0000_0000, 4'hF);
        check("reverse copy", rd, 32'hFFFE_FF5A);
    endtask
    task automatic text_scn();
        apb(1'b1, OFF_DEPTH, 32'h0000_0000);
        apb(1'b1, OFF_HSRC, 32'h0000_0010);
        apb(1'b1, OFF_DXY, 32'h0000_0124);
        apb(1'b1, OFF_APER, 32'h0000_0080);
        apb(1'b1, OFF_CTRL, 32'h0000_32CC);
        for (int x = 5; x > 3; x--) begin
            apb(1'b1, OFF_SXY, 32'(x));
            apb(1'b1, OFF_GO, 32'h0000_0001);
            wait_idle();
            fb(1'b0, 1'b1, 24'h00_0224, 32'h0000_0000, 4'hF);
            check("aperture onscreen", {31'h0, on}, 32'h0000_0001);
            check("bitmap pixel", rd,
                  (x == 5) ? 32'h1122_AB44 : 32'h1122_AB5A);
        end
    endtask
    initial begin
        i_clock = 1'b0;
        forever #4 i_clock = ~i_clock;
    end
    initial begin
        {i_psel, i_penable, i_pwrite, i_fb_req, i_fb_we, i_fb_legacy} = '0;
        {i_paddr, i_pwdata, i_fb_addr, i_fb_wdata} = '0;
        i_fb_be = 4'h0;
        mem_delay = 4'h0;
        bad_count = 0;
        samples_checked = 0;
        i_reset = 1'b1;
        repeat (6) @(posedge i_clock);
        i_reset <= 1'b0;
        @(posedge i_clock);
        regs_scn();
        host_scn();
        copy_scn();
        fill_scn();
        rev_scn();
        text_scn();
        close_out();
    end
endmodule
